// ---- core/wdg_top.sv ----
`timescale 1ns/1ps
`include "wdg_map.svh"
// Notes on behaviour
// [R01] watchdog runs from the slow rc tick; enabling it turns that oscillator on
// [R02] prescaler divides rc ticks by 32 or 128
// [R03] prescaler alone gives about 1 ms or 4 ms at 32 kHz
// [R04] postscaler divides prescaler output by one of sixteen ratios, 1:1 to 1:32768
// [R05] counters clear on reset, power-save entry and exit, and clear command
// [R06] counters also clear when a clock switch completes
// [R07] timeout in sleep or idle wakes the core instead of resetting
// [R08] software clears the sleep or idle status bit after waking
// [R09] always-on bit set makes the run-enable bit irrelevant
// [R10] always-on bit clear means watchdog runs only with run-enable set
// [R11] run-enable bit clears on every device reset
// [R12] window mode: clear before final quarter triggers a watchdog reset
// [R13] software should clear only within the final quarter in window mode
// [R14] timeout flag is sticky; only software or reset clears it
// [R15] postscale field is a power of two; all ones gives 1:32768
// [R16] prescale bit one selects 128, zero selects 32
// [R17] window-disable bit one means non-window, zero means window operation
// [R18] timeout while running resets the device and sets the flag
// [R19] timeout occurs when the postscaler reaches its terminal count
module wdg_top
  import wdg_pkg::*;
#(
  parameter int RC_DIV = `WDG_RC_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system events
  input wire logic clk_switch_done,
  input wire logic ext_wake,
  // system outputs
  output logic wdt_reset_req,
  output logic core_wake,
  output logic low_power_rc_osc_en,
  output logic [1:0] power_mode,
  output logic irq
);

  wdg_top_state_type q;
  wdg_top_state_type d;
  wdg_scl_if sif ();
  logic commit;
  logic wr;
  logic cmd_clr;
  logic cmd_sleep;
  logic cmd_idle;

  // ----------------------------------------
  // prescaler and postscaler
  // ----------------------------------------
  assign sif.tick = q.rc_tick;
  assign sif.clear = q.scl_clr;
  assign sif.run = q.osc_en;
  assign sif.pre_sel = q.cfg[`WDG_CFG_PRE];
  assign sif.post_sel = q.cfg[3:0];

  wdg_scaler u_scaler (
    .clk(pclk),
    .rst_n(presetn),
    .sif(sif)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.rc_tick = 1'b0;
    d.scl_clr = 1'b0;
    d.rst_out = 1'b0;
    d.wake_out = 1'b0;
    d.pslverr = 1'b0;
    d.pready = psel & penable & ~q.pready;
    commit = psel & penable & q.pready;
    wr = commit & pwrite;
    cmd_clr = 1'b0;
    cmd_sleep = 1'b0;
    cmd_idle = 1'b0;

    // slow rc oscillator runs whenever the watchdog is enabled
    d.osc_en = q.cfg[`WDG_CFG_ALWAYS] | q.sw_run; // R01 R09 R10
    if (!q.osc_en) begin
      d.rc_cnt = 12'h000;
    end else if (q.rc_cnt >= 12'(RC_DIV - 1)) begin
      d.rc_cnt = 12'h000;
      d.rc_tick = 1'b1; // R01
    end else begin
      d.rc_cnt = q.rc_cnt + 12'h001;
    end

    // software writes first so that hardware sets below win
    if (wr) begin
      if (paddr == `WDG_OFF_CFG) begin
        d.cfg = pwdata[7:0] & `WDG_CFG_MASK;
      end else if (paddr == `WDG_OFF_RSTCTL) begin
        d.sw_run = pwdata[`WDG_RC_SWEN];
        d.to_flag = q.to_flag & pwdata[`WDG_RC_TO]; // R14
        d.sleep_st = q.sleep_st & pwdata[`WDG_RC_SLEEP];
        d.idle_st = q.idle_st & pwdata[`WDG_RC_IDLE];
      end else if (paddr == `WDG_OFF_INT_CLR) begin
        d.int_st = q.int_st & ~pwdata[2:0];
      end else if (paddr == `WDG_OFF_INT_EN) begin
        d.int_en = pwdata[2:0];
      end else if (paddr == `WDG_OFF_CMD) begin
        cmd_clr = pwdata[`WDG_CMD_CLR];
        cmd_sleep = pwdata[`WDG_CMD_SLEEP];
        cmd_idle = pwdata[`WDG_CMD_IDLE];
      end
    end

    if (clk_switch_done) begin
      d.scl_clr = 1'b1; // R06
    end

    // ----------------------------------------
    // power mode and timeout handling
    // ----------------------------------------
    case (q.mode)
      WDG_MODE_RUN: begin
        if (sif.timeout) begin
          d.rst_out = 1'b1; // R18
          d.to_flag = 1'b1; // R14
          d.int_st[`WDG_INT_TO] = 1'b1;
        end else if (cmd_sleep || cmd_idle) begin
          d.mode = cmd_sleep ? WDG_MODE_SLEEP : WDG_MODE_IDLE;
          d.sleep_st = q.sleep_st | cmd_sleep;
          d.idle_st = q.idle_st | ~cmd_sleep;
          d.scl_clr = 1'b1; // R05
        end else if (cmd_clr && q.osc_en) begin
          d.scl_clr = 1'b1; // R05
          if (!q.cfg[`WDG_CFG_WINDOW_DISABLE_CONFIG] && !sif.in_window) begin
            d.rst_out = 1'b1; // R12 R17
            d.int_st[`WDG_INT_EARLY] = 1'b1;
          end
        end
      end
      WDG_MODE_SLEEP, WDG_MODE_IDLE: begin
        if (sif.timeout || ext_wake) begin
          d.mode = WDG_MODE_RUN;
          d.scl_clr = 1'b1; // R05
          if (sif.timeout) begin
            d.wake_out = 1'b1; // R07
            d.to_flag = 1'b1; // R14
            d.int_st[`WDG_INT_TO] = 1'b1;
            d.int_st[`WDG_INT_WAKE] = 1'b1;
          end
        end
      end
      default: begin
        d.mode = WDG_MODE_RUN;
      end
    endcase

    d.irq = |(d.int_st & d.int_en);

    // ----------------------------------------
    // read data and error answer
    // ----------------------------------------
    if (d.pready) begin
      d.prdata = 32'h00000000;
      if (paddr == `WDG_OFF_CFG) begin
        d.prdata[7:0] = q.cfg;
      end else if (paddr == `WDG_OFF_RSTCTL) begin
        d.prdata[`WDG_RC_SWEN] = q.sw_run;
        d.prdata[`WDG_RC_TO] = q.to_flag;
        d.prdata[`WDG_RC_SLEEP] = q.sleep_st;
        d.prdata[`WDG_RC_IDLE] = q.idle_st;
      end else if (paddr == `WDG_OFF_INT_STAT) begin
        d.prdata[2:0] = q.int_st;
      end else if (paddr == `WDG_OFF_INT_CLR) begin
        d.prdata = 32'h00000000;
      end else if (paddr == `WDG_OFF_INT_EN) begin
        d.prdata[2:0] = q.int_en;
      end else if (paddr == `WDG_OFF_CMD) begin
        d.prdata = 32'h00000000;
      end else if (paddr == `WDG_OFF_COUNT) begin
        d.prdata[14:0] = sif.post_cnt;
        d.prdata[`WDG_CNT_WIN] = sif.in_window;
      end else begin
        d.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cfg <= `WDG_CFG_RST;
      q.sw_run <= 1'b0; // R11
      q.mode <= WDG_MODE_RUN;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign wdt_reset_req = q.rst_out;
  assign core_wake = q.wake_out;
  assign low_power_rc_osc_en = q.osc_en;
  assign power_mode = q.mode;
  assign irq = q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_always_on_osc: assert property (
    q.cfg[`WDG_CFG_ALWAYS] [*2] |-> q.osc_en) // R01
    else $error("oscillator off while always-on set");

  chk_sw_enable_gate: assert property (
    (!q.cfg[`WDG_CFG_ALWAYS] && !q.sw_run) [*2] |=> !sif.timeout) // R10
    else $error("timeout while watchdog disabled");

  chk_swen_after_reset: assert property (
    $rose(presetn) |-> !q.sw_run) // R11
    else $error("run enable set after reset");

  chk_flag_sticky: assert property (
    (q.to_flag && !(wr && paddr == `WDG_OFF_RSTCTL)) |=> q.to_flag) // R14
    else $error("timeout flag dropped by itself");

  chk_run_timeout_reset: assert property (
    (sif.timeout && q.mode == WDG_MODE_RUN) |=> q.rst_out && q.to_flag && !q.wake_out) // R18
    else $error("no reset after running timeout");

  chk_sleep_timeout_wake: assert property (
    (sif.timeout && q.mode != WDG_MODE_RUN)
      |=> q.wake_out && !q.rst_out && q.mode == WDG_MODE_RUN ##1 q.scl_clr == 1'b0) // R07
    else $error("no wake after power-save timeout");

  chk_early_clear_reset: assert property (
    (cmd_clr && q.mode == WDG_MODE_RUN && q.osc_en && !sif.timeout
      && !q.cfg[`WDG_CFG_WINDOW_DISABLE_CONFIG] && !sif.in_window) |=> q.rst_out ##1 !q.rst_out) // R12
    else $error("early clear in window mode did not reset");

  chk_nonwindow_clear: assert property (
    (cmd_clr && q.cfg[`WDG_CFG_WINDOW_DISABLE_CONFIG] && !sif.timeout) |=> !q.rst_out) // R17
    else $error("clear reset the device in non-window mode");

  chk_switch_clears: assert property (
    clk_switch_done |=> q.scl_clr ##1 sif.post_cnt == 15'h0000) // R06
    else $error("clock switch did not clear counters");

  chk_apb_one_wait: assert property (
    (psel && penable && !q.pready) |=> q.pready ##1 !q.pready)
    else $error("apb answer not one cycle");

  chk_rc_tick_gated: assert property ( // R01
    !q.osc_en |=> !q.rc_tick)
    else $error("rc tick while oscillator off");

  chk_osc_follows_enable: assert property ( // R01 R09
    (q.cfg[`WDG_CFG_ALWAYS] || q.sw_run) |=> q.osc_en)
    else $error("oscillator not started when enabled");

  chk_osc_off_disabled: assert property ( // R10
    (!q.cfg[`WDG_CFG_ALWAYS] && !q.sw_run) |=> !q.osc_en)
    else $error("oscillator running while disabled");

  chk_rc_cnt_range: assert property ( // R01
    q.rc_cnt <= 12'(RC_DIV - 1))
    else $error("rc divider out of range");

  chk_tick_restarts: assert property ( // R01
    q.rc_tick |-> q.rc_cnt == 12'h000)
    else $error("rc divider not restarted on tick");

  chk_irq_level: assert property (
    q.irq == |(q.int_st & q.int_en))
    else $error("interrupt level wrong");

  chk_flag_on_timeout: assert property ( // R14
    sif.timeout |=> q.to_flag)
    else $error("timeout flag not set");

  chk_sleep_entry: assert property ( // R05 R07
    (cmd_sleep && q.mode == WDG_MODE_RUN && !sif.timeout)
      |=> q.mode == WDG_MODE_SLEEP && q.scl_clr && q.sleep_st)
    else $error("sleep entry wrong");

  chk_idle_entry: assert property ( // R05 R07
    (cmd_idle && !cmd_sleep && q.mode == WDG_MODE_RUN && !sif.timeout)
      |=> q.mode == WDG_MODE_IDLE && q.scl_clr && q.idle_st)
    else $error("idle entry wrong");

  chk_exit_clears: assert property ( // R05
    (q.mode != WDG_MODE_RUN && (sif.timeout || ext_wake))
      |=> q.mode == WDG_MODE_RUN && q.scl_clr)
    else $error("power-save exit did not clear counters");

  chk_clear_cmd: assert property ( // R05
    (cmd_clr && !cmd_sleep && !cmd_idle && q.mode == WDG_MODE_RUN
      && q.osc_en && !sif.timeout) |=> q.scl_clr)
    else $error("clear command did not clear counters");

  chk_stay_asleep: assert property ( // R07
    (q.mode != WDG_MODE_RUN && !sif.timeout && !ext_wake)
      |=> q.mode == $past(q.mode))
    else $error("power-save mode left without cause");

  chk_no_wake_running: assert property ( // R07
    q.mode == WDG_MODE_RUN |=> !q.wake_out)
    else $error("wake pulse while running");

  chk_no_reset_asleep: assert property ( // R07
    q.mode != WDG_MODE_RUN |=> !q.rst_out)
    else $error("reset request during power-save");

  chk_swen_write: assert property ( // R10
    (wr && paddr == `WDG_OFF_RSTCTL) |=> q.sw_run == $past(pwdata[`WDG_RC_SWEN]))
    else $error("run enable write lost");

  chk_window_clear_ok: assert property ( // R12
    (cmd_clr && q.mode == WDG_MODE_RUN && !sif.timeout && sif.in_window)
      |=> !q.rst_out)
    else $error("clear inside window reset the device");

  chk_err_with_ready: assert property (
    q.pslverr |-> q.pready)
    else $error("error without ready");

  chk_cfg_gap_zero: assert property (
    !q.cfg[5])
    else $error("unused config bit set");

endmodule

// ---- core/wdg_map.svh ----
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define WDG_CLK_HZ 125000000
`define WDG_RC_HZ 32000
`define WDG_RC_DIV (`WDG_CLK_HZ / `WDG_RC_HZ)

// ----------------------------------------
// scaler terminal counts
// ----------------------------------------
`define WDG_PRE32_LAST 7'h1F
`define WDG_PRE128_LAST 7'h7F
`define WDG_POST_MAX 15'h7FFF

// ----------------------------------------
// register offsets
// ----------------------------------------
`define WDG_OFF_CFG 8'h00
`define WDG_OFF_RSTCTL 8'h04
`define WDG_OFF_INT_STAT 8'h08
`define WDG_OFF_INT_CLR 8'h0C
`define WDG_OFF_INT_EN 8'h10
`define WDG_OFF_CMD 8'h14
`define WDG_OFF_COUNT 8'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define WDG_CFG_PRE 4
`define WDG_CFG_WINDOW_DISABLE_CONFIG 6
`define WDG_CFG_ALWAYS 7
`define WDG_CFG_RST 8'hDF
`define WDG_CFG_MASK 8'hDF
`define WDG_RC_IDLE 2
`define WDG_RC_SLEEP 3
`define WDG_RC_TO 4
`define WDG_RC_SWEN 5
`define WDG_INT_TO 0
`define WDG_INT_WAKE 1
`define WDG_INT_EARLY 2
`define WDG_CMD_CLR 0
`define WDG_CMD_SLEEP 1
`define WDG_CMD_IDLE 2
`define WDG_CNT_WIN 16

`endif

// ---- core/wdg_pkg.sv ----
package wdg_pkg;

  typedef enum logic [1:0] {
    WDG_MODE_RUN = 2'b00,
    WDG_MODE_SLEEP = 2'b01,
    WDG_MODE_IDLE = 2'b10
  } wdg_mode_type;

  typedef struct packed {
    logic [6:0] presc;
    logic [14:0] post;
    logic timeout;
  } wdg_scl_state_type;

  typedef struct packed {
    wdg_mode_type mode;
    logic [7:0] cfg;
    logic sw_run;
    logic to_flag;
    logic sleep_st;
    logic idle_st;
    logic [2:0] int_st;
    logic [2:0] int_en;
    logic [11:0] rc_cnt;
    logic rc_tick;
    logic scl_clr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rst_out;
    logic wake_out;
    logic osc_en;
    logic irq;
  } wdg_top_state_type;

endpackage

// ---- core/wdg_scl_if.sv ----
`timescale 1ns/1ps
interface wdg_scl_if;
  logic tick;
  logic clear;
  logic run;
  logic pre_sel;
  logic [3:0] post_sel;
  logic timeout;
  logic in_window;
  logic [14:0] post_cnt;
  modport ctl (
    output tick, clear, run, pre_sel, post_sel,
    input timeout, in_window, post_cnt
  );
  modport scl (
    input tick, clear, run, pre_sel, post_sel,
    output timeout, in_window, post_cnt
  );
endinterface

// ---- core/wdg_scaler.sv ----
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_scaler
  import wdg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  wdg_scl_if.scl sif
);

  wdg_scl_state_type q;
  wdg_scl_state_type d;
  logic [6:0] pre_last;
  logic [14:0] post_last;
  logic [22:0] elapsed;
  logic [22:0] period;

  // ----------------------------------------
  // terminal counts
  // ----------------------------------------
  assign pre_last = sif.pre_sel ? `WDG_PRE128_LAST : `WDG_PRE32_LAST; // R02 R16 R03
  assign post_last = `WDG_POST_MAX >> (4'hF - sif.post_sel); // R04 R15

  // ----------------------------------------
  // window: last quarter of the period
  // ----------------------------------------
  assign elapsed = sif.pre_sel ? {1'b0, q.post, q.presc} : {3'b000, q.post, q.presc[4:0]};
  assign period = sif.pre_sel ? {1'b0, post_last, 7'h00} + 23'h000080
                              : {3'b000, post_last, 5'h00} + 23'h000020;
  assign sif.in_window = elapsed >= (period - (period >> 2)); // R12
  assign sif.timeout = q.timeout;
  assign sif.post_cnt = q.post;

  always_comb begin
    d = q;
    d.timeout = 1'b0;
    if (sif.clear || !sif.run) begin
      d.presc = 7'h00; // R05 R06
      d.post = 15'h0000;
    end else if (sif.tick) begin
      if (q.presc >= pre_last) begin
        d.presc = 7'h00;
        if (q.post >= post_last) begin
          d.post = 15'h0000; // R19
          d.timeout = 1'b1;
        end else begin
          d.post = q.post + 15'h0001;
        end
      end else begin
        d.presc = q.presc + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  chk_clear_zeroes_counts: assert property (@(posedge clk) disable iff (!rst_n)
    sif.clear |=> (q.presc == 7'h00) && (q.post == 15'h0000) && !q.timeout) // R05
    else $error("scaler not cleared after clear");

  chk_timeout_at_terminal: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.timeout) |-> ($past(q.post) == $past(post_last))
      && ($past(q.presc) == $past(pre_last))) // R19
    else $error("timeout before terminal count");

endmodule

// ---- bench/wdg_top_tb.sv ----
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_top_tb
  import wdg_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int RCD = 4;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clk_switch_done = 1'b0;
  logic ext_wake = 1'b0;
  logic wdt_reset_req;
  logic core_wake;
  logic low_power_rc_osc_en;
  logic [1:0] power_mode;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic saw_rst;
  logic saw_wake;
  int error_cnt = 0;
  int cmp_count = 0;
  int rst_cnt = 0;
  int cnt;
  int r0;

  wdg_top #(.RC_DIV(RCD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_switch_done(clk_switch_done), .ext_wake(ext_wake), .wdt_reset_req(wdt_reset_req),
    .core_wake(core_wake), .low_power_rc_osc_en(low_power_rc_osc_en),
    .power_mode(power_mode), .irq(irq)
  );

  initial begin
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (wdt_reset_req === 1'b1) rst_cnt++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // timing window allows for rc tick phase
  task automatic near(input int c, input int e);
    logic ok;
    ok = (c >= e - 4) && (c <= e + RCD + 6);
    check(32'(ok ? e : c), 32'(e));
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic wait_evt(input int lim, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (wdt_reset_req !== 1'b1 && core_wake !== 1'b1 && c < lim);
    saw_rst = wdt_reset_req;
    saw_wake = core_wake;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(posedge pclk);
    check({31'h0, low_power_rc_osc_en}, 32'h1);
    rdchk(`WDG_OFF_CFG, 32'h000000DF);
    rdchk(`WDG_OFF_RSTCTL, 32'h0);
    rdchk(8'h1C, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, `WDG_OFF_INT_STAT, 32'h7);
    rdchk(`WDG_OFF_INT_STAT, 32'h0);
    rdchk(`WDG_OFF_INT_CLR, 32'h0);
  endtask

  task automatic t_period();
    logic [7:0] cf [4] = '{8'hC0, 8'hD0, 8'hC1, 8'hC2};
    int tk [4] = '{32, 128, 64, 128};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `WDG_OFF_CFG, {24'h0, cf[i]});
      apb(1'b1, `WDG_OFF_CMD, 32'h1);
      wait_evt(3000, cnt);
      near(cnt, tk[i] * RCD + 2);
      check({31'h0, saw_rst}, 32'h1);
    end
    rdchk(`WDG_OFF_RSTCTL, 32'h10);
    apb(1'b1, `WDG_OFF_RSTCTL, 32'h0);
    rdchk(`WDG_OFF_RSTCTL, 32'h0);
    apb(1'b1, `WDG_OFF_INT_EN, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `WDG_OFF_INT_CLR, 32'h7);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_swen();
    apb(1'b1, `WDG_OFF_CFG, 32'h40);
    repeat (3) @(posedge pclk);
    check({31'h0, low_power_rc_osc_en}, 32'h0);
    wait_evt(400, cnt);
    check({31'h0, saw_rst}, 32'h0);
    apb(1'b1, `WDG_OFF_RSTCTL, 32'h20);
    wait_evt(3000, cnt);
    check({31'h0, saw_rst}, 32'h1);
    check({31'h0, low_power_rc_osc_en}, 32'h1);
    apb(1'b1, `WDG_OFF_RSTCTL, 32'h0);
    apb(1'b1, `WDG_OFF_CFG, 32'hC0);
    apb(1'b1, `WDG_OFF_CMD, 32'h1);
    wait_evt(3000, cnt);
    near(cnt, 32 * RCD + 2);
  endtask

  task automatic t_power();
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `WDG_OFF_CMD, k ? 32'h4 : 32'h2);
      @(posedge pclk);
      check({30'h0, power_mode}, k ? 32'h2 : 32'h1);
      wait_evt(3000, cnt);
      near(cnt, 32 * RCD + 1);
      check({30'h0, saw_wake, saw_rst}, 32'h2);
      @(posedge pclk);
      check({30'h0, power_mode}, 32'h0);
      apb(1'b0, `WDG_OFF_RSTCTL, 32'h0);
      check(rd & 32'hC, k ? 32'h4 : 32'h8);
      apb(1'b1, `WDG_OFF_RSTCTL, 32'h0);
      rdchk(`WDG_OFF_RSTCTL, 32'h0);
    end
    apb(1'b1, `WDG_OFF_CMD, 32'h2);
    repeat (80) @(posedge pclk);
    ext_wake <= 1'b1;
    @(posedge pclk);
    ext_wake <= 1'b0;
    wait_evt(3000, cnt);
    near(cnt, 32 * RCD + 2);
    check({31'h0, saw_rst}, 32'h1);
  endtask

  task automatic t_switch();
    apb(1'b1, `WDG_OFF_CMD, 32'h1);
    repeat (80) @(posedge pclk);
    clk_switch_done <= 1'b1;
    @(posedge pclk);
    clk_switch_done <= 1'b0;
    wait_evt(3000, cnt);
    near(cnt, 32 * RCD + 2);
  endtask

  task automatic t_window();
    apb(1'b1, `WDG_OFF_CFG, 32'h80);
    apb(1'b1, `WDG_OFF_INT_CLR, 32'h7);
    wait_evt(3000, cnt);
    repeat (20) @(posedge pclk);
    r0 = rst_cnt;
    apb(1'b1, `WDG_OFF_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(rst_cnt - r0), 32'h1);
    rdchk(`WDG_OFF_INT_STAT, 32'h5);
    apb(1'b1, `WDG_OFF_INT_CLR, 32'h7);
    wait_evt(3000, cnt);
    repeat (106) @(posedge pclk);
    r0 = rst_cnt;
    apb(1'b1, `WDG_OFF_CMD, 32'h1);
    repeat (4) @(posedge pclk);
    check(32'(rst_cnt - r0), 32'h0);
    wait_evt(3000, cnt);
    near(cnt, 32 * RCD - 4);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end

  initial begin
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_period();
    t_swen();
    t_power();
    t_switch();
    t_window();
    stop_test();
  end
endmodule
